// ==== hdl/lem_line_event_monitor.sv ====
// line event monitor: billing tone flags, line monitor and loop level
`timescale 1ns/1ps
module lem_line_event_monitor #(
	parameter int ADDR_W = lem_pkg::ADDR_W,
	parameter int RECOVER_CYCLES = lem_pkg::RECOVER_CYC,
	parameter int MA_W = 8
) (
	// clock, reset, enable
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic ce,
	// axi4-lite write address
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// ac-link pins
	input wire logic ac_bit_clk,
	input wire logic ac_sync,
	input wire logic ac_sdata_out,
	output logic ac_sdata_in,
	// line-side comparators
	input wire logic adc_over_in,
	input wire logic supply_low_in,
	input wire logic ring_above_in,
	input wire logic ring_below_in,
	input wire logic line_present_in,
	input wire logic off_hook_in,
	// line-side converters, same clock
	input wire logic [15:0] mon_adc_data,
	input wire logic [MA_W-1:0] loop_ma,
	input wire logic loop_valid,
	// line-side controls
	output logic dc_release_q,
	output logic low_power_adc_en_q,
	output logic ring_squelch_q
);
	localparam int PIN_BCLK = 0;
	localparam int PIN_SYNC = 1;
	localparam int PIN_SDO = 2;
	localparam int PIN_OVER = 3;
	localparam int PIN_SUPPLY = 4;
	localparam int PIN_RPOS = 5;
	localparam int PIN_RNEG = 6;
	localparam int PIN_LINE = 7;
	localparam int PIN_HOOK = 8;
	localparam int NPIN = 9;

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	logic [NPIN-1:0] pin_raw;
	logic [NPIN-1:0] pin_s;

	assign pin_raw[PIN_BCLK] = ac_bit_clk;
	assign pin_raw[PIN_SYNC] = ac_sync;
	assign pin_raw[PIN_SDO] = ac_sdata_out;
	assign pin_raw[PIN_OVER] = adc_over_in;
	assign pin_raw[PIN_SUPPLY] = supply_low_in;
	assign pin_raw[PIN_RPOS] = ring_above_in;
	assign pin_raw[PIN_RNEG] = ring_below_in;
	assign pin_raw[PIN_LINE] = line_present_in;
	assign pin_raw[PIN_HOOK] = off_hook_in;

	genvar gi;
	generate
		for (gi = 0; gi < NPIN; gi++) begin : g_sync
			logic meta_q;
			logic hold_q;
			always_ff @(posedge clk_sys or negedge arst_n) begin
				if (!arst_n) begin
					meta_q <= 1'b0;
					hold_q <= 1'b0;
				end else if (ce) begin
					meta_q <= pin_raw[gi];
					hold_q <= meta_q;
				end
			end
			assign pin_s[gi] = hold_q;
		end
	endgenerate

	wire over_s = pin_s[PIN_OVER];
	wire supply_s = pin_s[PIN_SUPPLY];
	wire line_s = pin_s[PIN_LINE];
	wire hook_s = pin_s[PIN_HOOK];

	////////////////////////////////////////////////////////////////////////
	// axi4-lite slave; one write and one read in flight
	logic aw_got_q;
	logic w_got_q;
	logic [ADDR_W-1:0] aw_addr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic [31:0] rdata_d;
	logic [1:0] rresp_d;

	wire aw_hs = s_axi_awvalid & s_axi_awready;
	wire w_hs = s_axi_wvalid & s_axi_wready;
	wire ar_hs = s_axi_arvalid & s_axi_arready;
	wire do_write = aw_got_q & w_got_q & ~s_axi_bvalid;
	wire aw_got_d = (aw_got_q | aw_hs) & ~do_write;
	wire w_got_d = (w_got_q | w_hs) & ~do_write;
	wire bvalid_d = do_write | (s_axi_bvalid & ~s_axi_bready);
	wire awready_d = ~aw_got_d & ~bvalid_d;
	wire wready_d = ~w_got_d & ~bvalid_d;
	wire rvalid_d = ar_hs | (s_axi_rvalid & ~s_axi_rready);
	wire arready_d = ~rvalid_d;

	wire [ADDR_W-1:0] wa = {aw_addr_q[ADDR_W-1:2], 2'h0};
	wire [ADDR_W-1:0] ra = {s_axi_araddr[ADDR_W-1:2], 2'h0};
	wire w_ctrl = wa == ADDR_W'(lem_pkg::CTRL_ADDR);
	wire w_stat = wa == ADDR_W'(lem_pkg::STAT_ADDR);
	wire w_mon = wa == ADDR_W'(lem_pkg::MON_ADDR);
	wire r_ctrl = ra == ADDR_W'(lem_pkg::CTRL_ADDR);
	wire r_stat = ra == ADDR_W'(lem_pkg::STAT_ADDR);
	wire r_mon = ra == ADDR_W'(lem_pkg::MON_ADDR);
	wire w_hit = w_ctrl | w_stat | w_mon;
	wire ctrl_wr = do_write & w_ctrl & wstrb_q[0];
	wire stat_wr = do_write & w_stat & wstrb_q[0];
	wire [1:0] bresp_d = w_hit ? lem_pkg::RESP_OKAY : lem_pkg::RESP_SLVERR;

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			aw_addr_q <= '0;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
		end else if (ce) begin
			aw_got_q <= aw_got_d;
			w_got_q <= w_got_d;
			s_axi_awready <= awready_d;
			s_axi_wready <= wready_d;
			s_axi_bvalid <= bvalid_d;
			if (aw_hs) aw_addr_q <= s_axi_awaddr;
			if (w_hs) wdata_q <= s_axi_wdata;
			if (w_hs) wstrb_q <= s_axi_wstrb;
			if (do_write) s_axi_bresp <= bresp_d;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= 2'h0;
		end else if (ce) begin
			s_axi_arready <= arready_d;
			s_axi_rvalid <= rvalid_d;
			if (ar_hs) s_axi_rdata <= rdata_d;
			if (ar_hs) s_axi_rresp <= rresp_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// control register
	logic bde_q;

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			bde_q <= 1'b0;
			ring_squelch_q <= 1'b0;
		end else if (ce && ctrl_wr) begin
			bde_q <= wdata_q[lem_pkg::CTRL_BDE];
			ring_squelch_q <= wdata_q[lem_pkg::CTRL_SQL];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// billing tone flags and dc termination
	logic ovf_q;
	logic btf_q;
	logic [31:0] rec_cnt_q;

	wire ovf_set = bde_q & over_s;
	wire btf_set = bde_q & supply_s;
	wire ovf_clr = stat_wr & ~wdata_q[lem_pkg::ST_OVF];
	wire btf_clr = stat_wr & ~wdata_q[lem_pkg::ST_BTF];
	wire ovf_d = ovf_set | (ovf_q & ~ovf_clr);
	wire btf_d = btf_set | (btf_q & ~btf_clr);
	// release holds while the flag or the enable stays up
	wire rec_hold = btf_q | bde_q;
	wire rec_done = rec_cnt_q >= 32'(RECOVER_CYCLES - 1);
	wire dcr_d = btf_q | (dc_release_q & (rec_hold | ~rec_done));

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			ovf_q <= 1'b0;
			btf_q <= 1'b0;
			dc_release_q <= 1'b0;
			rec_cnt_q <= 32'h00000000;
		end else if (ce) begin
			ovf_q <= ovf_d;
			btf_q <= btf_d;
			dc_release_q <= dcr_d;
			if (rec_hold || !dc_release_q) begin
				rec_cnt_q <= 32'h00000000;
			end else if (!rec_done) begin
				rec_cnt_q <= rec_cnt_q + 32'h00000001;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// on-hook line monitor
	lem_link_if lk ();
	logic [15:0] sample_w;
	logic [3:0] level;

	wire mon_any = lk.mon_first | lk.mon_second;

	// a missing line drags the converter to negative full scale
	always_comb begin
		if (!mon_any) begin
			sample_w = lem_pkg::SMP_IDLE;
		end else if (line_s) begin
			sample_w = mon_adc_data;
		end else begin
			sample_w = lem_pkg::NEG_FULL;
		end
	end

	assign lk.sample = sample_w;

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			low_power_adc_en_q <= 1'b0;
		end else if (ce) begin
			low_power_adc_en_q <= mon_any;
		end
	end

	lem_aclink u_link (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.ce(ce),
		.bclk_s(pin_s[PIN_BCLK]),
		.sync_s(pin_s[PIN_SYNC]),
		.sdo_s(pin_s[PIN_SDO]),
		.sdi_q(ac_sdata_in),
		.lk(lk.link)
	);

	lem_loop_level #(
		.MA_W(MA_W)
	) u_level (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.ce(ce),
		.meas_valid(loop_valid),
		.meas_ma(loop_ma),
		.off_hook(hook_s),
		.monitor_on(mon_any),
		.line_present(line_s),
		.level_q(level)
	);

	////////////////////////////////////////////////////////////////////////
	// read words
	logic [31:0] ctrl_word;
	logic [31:0] stat_word;
	logic [31:0] mon_word;

	always_comb begin
		ctrl_word = 32'h00000000;
		ctrl_word[lem_pkg::CTRL_BDE] = bde_q;
		ctrl_word[lem_pkg::CTRL_SQL] = ring_squelch_q;
		stat_word = 32'h00000000;
		stat_word[lem_pkg::ST_OVF] = ovf_q;
		stat_word[lem_pkg::ST_BTF] = btf_q;
		stat_word[lem_pkg::ST_OVL] = over_s;
		stat_word[lem_pkg::ST_RPOS] = pin_s[PIN_RPOS];
		stat_word[lem_pkg::ST_RNEG] = pin_s[PIN_RNEG];
		stat_word[lem_pkg::ST_LCL +: 4] = level;
		stat_word[lem_pkg::ST_DCR] = dc_release_q;
		mon_word = 32'h00000000;
		mon_word[lem_pkg::MON_SMP +: 16] = sample_w;
		mon_word[lem_pkg::MON_FIRST] = lk.mon_first;
		mon_word[lem_pkg::MON_SECOND] = lk.mon_second;
	end

	always_comb begin
		rdata_d = 32'h00000000;
		rresp_d = lem_pkg::RESP_OKAY;
		if (r_ctrl) begin
			rdata_d = ctrl_word;
		end else if (r_stat) begin
			rdata_d = stat_word;
		end else if (r_mon) begin
			rdata_d = mon_word;
		end else begin
			rresp_d = lem_pkg::RESP_SLVERR;
		end
	end
endmodule

// ==== shared/lem_pkg.sv ====
// constants for the line event monitor
package lem_pkg;
	// register map
	localparam int ADDR_W = 12;
	localparam logic [7:0] CTRL_IDX = 8'h5C;
	localparam logic [7:0] STAT_IDX = 8'h5E;
	localparam logic [7:0] MON_IDX = 8'h60;
	localparam logic [11:0] CTRL_ADDR = {2'h0, CTRL_IDX, 2'h0};
	localparam logic [11:0] STAT_ADDR = {2'h0, STAT_IDX, 2'h0};
	localparam logic [11:0] MON_ADDR = {2'h0, MON_IDX, 2'h0};
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// control fields
	localparam int CTRL_BDE = 0;
	localparam int CTRL_SQL = 1;
	// status fields
	localparam int ST_OVF = 0;
	localparam int ST_BTF = 1;
	localparam int ST_OVL = 2;
	localparam int ST_RPOS = 3;
	localparam int ST_RNEG = 4;
	localparam int ST_LCL = 8;
	localparam int ST_DCR = 12;
	// monitor fields
	localparam int MON_SMP = 0;
	localparam int MON_FIRST = 16;
	localparam int MON_SECOND = 17;
	// timing
	localparam int CLK_MHZ = 125;
	localparam int RECOVER_MS = 1000;
	localparam int RECOVER_CYC = RECOVER_MS * 1000 * CLK_MHZ;
	// ac-link frame layout
	localparam int SLOT0_BITS = 16;
	localparam int SLOT_BITS = 20;
	localparam int GPIO_MSB = 15;
	localparam int GPIO_LINE1 = 2;
	localparam int GPIO_LINE2 = 12;
	localparam int SLOT12_START = SLOT0_BITS + 11 * SLOT_BITS;
	localparam int SLOT5_START = SLOT0_BITS + 4 * SLOT_BITS;
	localparam logic [7:0] TAG_READY = 8'h00;
	localparam logic [7:0] TAG_SLOT5 = 8'h05;
	localparam logic [7:0] SMP_FIRST = 8'(SLOT5_START);
	localparam logic [7:0] MON1_BIT = 8'(SLOT12_START + GPIO_MSB - GPIO_LINE1);
	localparam logic [7:0] MON2_BIT = 8'(SLOT12_START + GPIO_MSB - GPIO_LINE2);
	localparam logic [15:0] NEG_FULL = 16'h8000;
	localparam logic [15:0] SMP_IDLE = 16'h0000;
	// loop current levels
	localparam logic [7:0] LCL_STEP_MA = 8'h06;
	localparam logic [7:0] LCL_HYST_MA = 8'h02;
	localparam logic [7:0] LCL_TOP_MA = 8'h9B;
	localparam logic [3:0] LCL_NONE = 4'h0;
	localparam logic [3:0] LCL_MAXSTEP = 4'hE;
	localparam logic [3:0] LCL_OVER = 4'hF;
endpackage

// ==== shared/lem_link_if.sv ====
// signals between the register core and the ac-link serialiser
`timescale 1ns/1ps
interface lem_link_if;
	logic mon_first;
	logic mon_second;
	logic [15:0] sample;
	modport link (output mon_first, output mon_second, input sample);
	modport core (input mon_first, input mon_second, output sample);
endinterface

// ==== hdl/lem_aclink.sv ====
// ac-link bit serialiser: slot 12 monitor bits in, slot 5 samples out
`timescale 1ns/1ps
module lem_aclink (
	// clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic ce,
	// synchronised link pins
	input wire logic bclk_s,
	input wire logic sync_s,
	input wire logic sdo_s,
	output logic sdi_q,
	// core side
	lem_link_if.link lk
);
	logic bclk_prev_q;
	logic sync_prev_q;
	logic [7:0] bit_q;
	logic [15:0] word_q;
	logic first_q;
	logic second_q;
	logic sdi_d;
	wire rise = bclk_s & ~bclk_prev_q;
	wire fall = ~bclk_s & bclk_prev_q;
	wire frame_start = fall & sync_s & ~sync_prev_q;
	wire [7:0] cur_idx = frame_start ? lem_pkg::TAG_READY : bit_q;
	wire mon_any = first_q | second_q;
	wire [7:0] smp_off = bit_q - lem_pkg::SMP_FIRST;
	wire in_smp = (bit_q >= lem_pkg::SMP_FIRST) && (smp_off < 8'h10);

	assign lk.mon_first = first_q;
	assign lk.mon_second = second_q;

	// samples only go out while a monitor bit is set
	always_comb begin
		sdi_d = 1'b0;
		if (bit_q == lem_pkg::TAG_READY) begin
			sdi_d = 1'b1;
		end else if (bit_q == lem_pkg::TAG_SLOT5) begin
			sdi_d = mon_any;
		end else if (in_smp) begin
			sdi_d = mon_any & word_q[~smp_off[3:0]];
		end
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			bclk_prev_q <= 1'b0;
			sync_prev_q <= 1'b0;
			bit_q <= 8'h00;
			word_q <= 16'h0000;
			first_q <= 1'b0;
			second_q <= 1'b0;
			sdi_q <= 1'b0;
		end else if (ce) begin
			bclk_prev_q <= bclk_s;
			if (fall) begin
				sync_prev_q <= sync_s;
				bit_q <= cur_idx + 8'h01;
				if (cur_idx == lem_pkg::MON1_BIT) first_q <= sdo_s;
				if (cur_idx == lem_pkg::MON2_BIT) second_q <= sdo_s;
			end
			if (frame_start) word_q <= lk.sample;
			if (rise) sdi_q <= sdi_d;
		end
	end
endmodule

// ==== hdl/lem_loop_level.sv ====
// loop current quantiser with hysteresis
`timescale 1ns/1ps
module lem_loop_level #(
	parameter int MA_W = 8
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic ce,
	// measurement
	input wire logic meas_valid,
	input wire logic [MA_W-1:0] meas_ma,
	input wire logic off_hook,
	input wire logic monitor_on,
	input wire logic line_present,
	// result
	output logic [3:0] level_q
);
	localparam int W = MA_W + 4;
	logic [3:0] level_d;
	logic [3:0] target;
	wire [W-1:0] cur = W'(meas_ma);
	wire [W-1:0] step = W'(lem_pkg::LCL_STEP_MA);
	wire [W-1:0] hyst = W'(lem_pkg::LCL_HYST_MA);
	wire [W-1:0] top = W'(lem_pkg::LCL_TOP_MA);
	wire [W-1:0] quot = cur / step;
	wire [W-1:0] lo_tgt = lo_of(target);
	wire [W-1:0] lo_cur = lo_of(level_q);

	function automatic logic [W-1:0] lo_of(input logic [3:0] c);
		if (c == lem_pkg::LCL_OVER) begin
			lo_of = top + W'(1);
		end else begin
			lo_of = W'(c) * step;
		end
	endfunction

	always_comb begin
		if (cur > top) begin
			target = lem_pkg::LCL_OVER;
		end else if (quot > W'(lem_pkg::LCL_MAXSTEP)) begin
			target = lem_pkg::LCL_MAXSTEP;
		end else begin
			target = quot[3:0];
		end
	end

	// rise at the band edge, fall only more than 2 mA below it
	always_comb begin
		level_d = level_q;
		if (monitor_on && !off_hook) begin
			level_d = line_present ? lem_pkg::LCL_OVER : lem_pkg::LCL_NONE;
		end else if (!off_hook) begin
			level_d = lem_pkg::LCL_NONE;
		end else if (meas_valid) begin
			if (target > level_q && cur >= lo_tgt) begin
				level_d = target;
			end else if (target < level_q && cur + hyst < lo_cur) begin
				level_d = target;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			level_q <= 4'h0;
		end else if (ce) begin
			level_q <= level_d;
		end
	end
endmodule

// ==== tb/lem_port_monitor.sv ====
// port-level assertion checker for the line event monitor
`timescale 1ns/1ps
module lem_port_monitor (
	// clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	// register bus
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// link and line side
	input wire logic ac_bit_clk,
	input wire logic ac_sdata_in,
	input wire logic supply_low_in,
	input wire logic dc_release_q,
	input wire logic ring_squelch_q
);
	logic [7:0] sup_q;
	logic [7:0] bclk_q;
	wire bclk_rise = |(bclk_q[6:0] & ~bclk_q[7:1]);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	// short pin history; pins are synchronised inside so causes lag
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			sup_q <= 8'h00;
			bclk_q <= 8'h00;
		end else begin
			sup_q <= {sup_q[6:0], supply_low_in};
			bclk_q <= {bclk_q[6:0], ac_bit_clk};
		end
	end
	////////////////////////////////////////////////////////////////////////
	a_bvalid_stands: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	a_rvalid_stands: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	a_write_refused: assert property (s_axi_bvalid
		|-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while data pending");
	a_write_reopen: assert property (s_axi_bvalid && s_axi_bready
		|=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
		else $error("write channel not reopened");
	a_read_reopen: assert property (s_axi_rvalid && s_axi_rready
		|=> !s_axi_rvalid && s_axi_arready)
		else $error("read channel not reopened");
	a_squelch_write: assert property ($changed(ring_squelch_q)
		|-> $rose(s_axi_bvalid))
		else $error("squelch changed without a write");
	a_dc_cause: assert property ($rose(dc_release_q) |-> |sup_q)
		else $error("dc release without supply collapse");
	a_sdi_on_rise: assert property ($changed(ac_sdata_in) |-> bclk_rise)
		else $error("link data changed away from bit clock rise");
	c_write: cover property (s_axi_bvalid && s_axi_bready);
	c_read: cover property (s_axi_rvalid && s_axi_rready);
	c_dc_on: cover property ($rose(dc_release_q));
	c_dc_off: cover property ($fell(dc_release_q));
endmodule
bind lem_line_event_monitor lem_port_monitor mon_u (.*);

// ==== tb/lem_ac97_ctrl_model.sv ====
// link controller model: bursts of back-to-back 256-bit frames
`timescale 1ns/1ps
module lem_ac97_ctrl_model (
	// link pins
	output logic ac_bit_clk,
	output logic ac_sync,
	output logic ac_sdata_out,
	input wire logic ac_sdata_in
);
	logic [255:0] tx;
	logic [255:0] rx_q;
	logic [15:0] slot5_q;
	logic [15:0] prev_q;
	logic [15:0] hp_q;
	initial begin
		prev_q = 16'h0000;
		ac_bit_clk = 1'h0;
		ac_sync = 1'h0;
		ac_sdata_out = 1'h0;
	end
	// bit clock only runs inside a burst, idle low between bursts
	task automatic run(input int frames, input logic m1, input logic m2);
		for (int f = 0; f < frames; f++) begin
			tx = '0;
			tx[lem_pkg::MON1_BIT] = m1;
			tx[lem_pkg::MON2_BIT] = m2;
			for (int i = 0; i < 256; i++) begin
				#3;
				ac_bit_clk = 1'h1;
				ac_sync = (i < 16);
				ac_sdata_out = tx[i];
				#40;
				ac_bit_clk = 1'h0;
				rx_q[i] = ac_sdata_in;
				if (i >= 96 && i < 112) slot5_q = {slot5_q[14:0], ac_sdata_in};
				#37;
			end
			// first difference strips the converter's dc offset
			hp_q = slot5_q - prev_q;
			prev_q = slot5_q;
		end
		ac_sync = 1'h0;
		ac_sdata_out = ~ac_sdata_out;
	endtask
endmodule

// ==== tb/tb.sv ====
// self-checking bench for the line event monitor
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
	checks++; \
	if ((g) !== (e)) begin \
		errors++; \
		$display("Error %s expected %h seen %h", nm, e, g); \
	end \
end
module tb;
	localparam logic [11:0] CTRL = lem_pkg::CTRL_ADDR;
	localparam logic [11:0] STAT = lem_pkg::STAT_ADDR;
	// rows: off_hook, loop_ma, expected level
	localparam logic [12:0] ROWS [10] = '{{1'h1, 8'h03, 4'h0},
		{1'h1, 8'h06, 4'h1}, {1'h1, 8'h1E, 4'h5},
		{1'h1, 8'h1D, 4'h5}, {1'h1, 8'h1B, 4'h4},
		{1'h1, 8'h54, 4'hE}, {1'h1, 8'h2A, 4'h7},
		{1'h1, 8'h9B, 4'hE}, {1'h1, 8'h9C, 4'hF},
		{1'h0, 8'h3C, 4'h0}};
	logic clk_sys, arst_n, ce, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
	logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [2:0] s_axi_awprot, s_axi_arprot;
	logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	logic ac_bit_clk, ac_sync, ac_sdata_out, ac_sdata_in;
	logic adc_over_in, supply_low_in, ring_above_in, ring_below_in;
	logic line_present_in, off_hook_in, loop_valid;
	logic [15:0] mon_adc_data;
	logic [7:0] loop_ma;
	logic dc_release_q, low_power_adc_en_q, ring_squelch_q;
	int errors, checks;
	lem_line_event_monitor #(.RECOVER_CYCLES(20)) dut_u (.*);
	lem_ac97_ctrl_model pm_u (.*);
	always #4 clk_sys = ~clk_sys;
	////////////////////////////////////////////////////////////////////////
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		do begin
			@(posedge clk_sys);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (s_axi_bvalid !== 1'h1);
		s_axi_bready <= 1'h1;
		do begin
			@(posedge clk_sys);
		end while (s_axi_bvalid !== 1'h1);
		resp = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask
	task automatic rd(input logic [11:0] a);
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		do begin
			@(posedge clk_sys);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (s_axi_rvalid !== 1'h1);
		s_axi_rready <= 1'h1;
		do begin
			@(posedge clk_sys);
		end while (s_axi_rvalid !== 1'h1);
		rdat = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask
	task automatic finish_test;
		if (errors == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic pins(input logic over, input logic low);
		@(posedge clk_sys);
		adc_over_in <= over;
		supply_low_in <= low;
		repeat (8) @(posedge clk_sys);
	endtask
	initial begin
		repeat (60000) @(posedge clk_sys);
		errors++;
		finish_test();
	end
	initial begin
		{clk_sys, arst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
		{s_axi_awprot, s_axi_arprot, s_axi_wdata, adc_over_in} = '0;
		{supply_low_in, ring_above_in, ring_below_in, line_present_in} = '0;
		{off_hook_in, loop_valid, mon_adc_data, loop_ma} = '0;
		{errors, checks} = '0;
		ce = 1'h1;
		s_axi_wstrb = 4'hF;
		repeat (10) @(posedge clk_sys);
		arst_n <= 1'h1;
		rd(CTRL);
		`CHK("ctrl reset", 32'h0, rdat);
		loop_valid <= 1'h1;
		for (int i = 0; i < 10; i++) begin
			@(posedge clk_sys);
			{off_hook_in, loop_ma} <= ROWS[i][12:4];
			repeat (6) @(posedge clk_sys);
			rd(STAT);
			`CHK("loop level", ROWS[i][3:0], rdat[11:8]);
		end
		rd(12'h004);
		`CHK("unmapped read", {lem_pkg::RESP_SLVERR, 32'h0}, {resp, rdat});
		wr(12'h004, 32'hFFFFFFFF);
		`CHK("unmapped write", lem_pkg::RESP_SLVERR, resp);
		for (int i = 0; i < 3; i++) begin
			@(posedge clk_sys);
			{ring_above_in, ring_below_in} <= 2'(i);
			repeat (6) @(posedge clk_sys);
			rd(STAT);
			`CHK("ring flags", {i[0], i[1]}, rdat[4:3]);
		end
		pins(1'h1, 1'h1);
		pins(1'h0, 1'h0);
		rd(STAT);
		`CHK("flags disabled", 2'h0, rdat[1:0]);
		wr(CTRL, 32'h1);
		pins(1'h1, 1'h0);
		rd(STAT);
		`CHK("overload set", 3'h5, rdat[2:0]);
		pins(1'h0, 1'h0);
		@(posedge clk_sys);
		adc_over_in <= 1'h1;
		// one-cycle pulse lands on the same edge as the clearing write
		fork
			wr(STAT, 32'h0);
			begin
				@(posedge clk_sys);
				adc_over_in <= 1'h0;
			end
		join
		rd(STAT);
		`CHK("set beats clear", 1'h1, rdat[0]);
		pins(1'h0, 1'h1);
		pins(1'h0, 1'h0);
		rd(STAT);
		`CHK("tone flags", {1'h1, 3'h3}, {rdat[12], rdat[2:0]});
		`CHK("dc release", 1'h1, dc_release_q);
		wr(STAT, 32'hFFFFFFFF);
		rd(STAT);
		`CHK("write one keeps", 2'h3, rdat[1:0]);
		wr(STAT, 32'h0);
		rd(STAT);
		`CHK("write zero clears", 3'h0, rdat[2:0]);
		wr(CTRL, 32'h0);
		`CHK("dc still released", 1'h1, dc_release_q);
		repeat (30) @(posedge clk_sys);
		`CHK("dc restored", 1'h0, dc_release_q);
		wr(CTRL, 32'h3);
		`CHK("squelch on", 1'h1, ring_squelch_q);
		wr(CTRL, 32'h0);
		`CHK("squelch off", 1'h0, ring_squelch_q);
		@(posedge clk_sys);
		line_present_in <= 1'h1;
		mon_adc_data <= 16'h0123;
		pm_u.run(3, 1'h1, 1'h0);
		`CHK("monitor on", 3'h7, {low_power_adc_en_q, pm_u.rx_q[5], pm_u.rx_q[0]});
		`CHK("line sample", 16'h0123, pm_u.slot5_q);
		`CHK("dc removed", 16'h0000, pm_u.hp_q);
		rd(STAT);
		`CHK("line level", 4'hF, rdat[11:8]);
		rd(lem_pkg::MON_ADDR);
		`CHK("monitor reg", 18'h10123, rdat[17:0]);
		line_present_in <= 1'h0;
		pm_u.run(3, 1'h0, 1'h1);
		`CHK("no line sample", lem_pkg::NEG_FULL, pm_u.slot5_q);
		rd(STAT);
		`CHK("no line level", 4'h0, rdat[11:8]);
		pm_u.run(3, 1'h0, 1'h0);
		`CHK("monitor off", 17'h0, {low_power_adc_en_q, pm_u.slot5_q});
		wr(CTRL, 32'h3);
		// a frozen block must not see the supply collapse at all
		ce <= 1'h0;
		pins(1'h0, 1'h1);
		pins(1'h0, 1'h0);
		ce <= 1'h1;
		rd(STAT);
		`CHK("frozen flag", 1'h0, rdat[1]);
		arst_n <= 1'h0;
		repeat (3) @(posedge clk_sys);
		`CHK("reset outputs", 2'h0, {ring_squelch_q, dc_release_q});
		arst_n <= 1'h1;
		rd(CTRL);
		`CHK("ctrl after reset", 32'h0, rdat);
		finish_test();
	end
endmodule
